// *** common/reset_ctrl_pkg.sv ***
package reset_ctrl_pkg;

  // last reset cause encodings
  localparam logic [2:0] CAUSE_POWERUP  = 3'h0;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER     = 3'h4;
  localparam logic [2:0] CAUSE_BROWNOUT = 3'h5;
  localparam logic [2:0] CAUSE_RST      = 3'h0;

  // control word layout
  localparam logic [7:0] CTRL_KEY_VALUE  = 8'hA5;
  localparam int         CTRL_KEY_LSB    = 24;
  localparam int         CTRL_CPU_BIT    = 0;
  localparam int         CTRL_PERIPH_BIT = 2;
  localparam int         CTRL_PIN_BIT    = 3;

  // timing counts in slow clock cycles
  localparam int STARTUP_CYCLES      = 64;
  localparam int CPU_STARTUP_CYCLES  = 3;
  localparam int SW_RESET_CYCLES     = 3;
  localparam int WDOG_RESET_CYCLES   = 3;
  localparam int BROWNOUT_EXIT_CYCLES = 3;
  localparam int PULSE_CNT_W         = 17;
  localparam int PHASE_CNT_W         = 16;

  typedef enum logic [2:0]
  {
    ST_STARTUP = 3'h0,
    ST_RUN     = 3'h1,
    ST_USER    = 3'h3,
    ST_SOFT    = 3'h2,
    ST_WDOG    = 3'h6,
    ST_BROWN   = 3'h7
  } state_type;

  typedef struct packed
  {
    logic       brownout_irq_enable;
    logic [3:0] ext_reset_length_field;
    logic       user_reset_irq_enable;
    logic       user_reset_enable;
  } mode_type;

  typedef struct packed
  {
    logic       sw_reset_busy;
    logic       pin_level_flag;
    logic [2:0] last_reset_cause;
    logic       brownout_seen_flag;
    logic       user_reset_seen_flag;
  } status_type;

endpackage

// *** rtl/system_reset_controller.sv ***
`timescale 1ns/1ps
`default_nettype none

module system_reset_controller
  #(
    parameter int STARTUP_LEN = reset_ctrl_pkg::STARTUP_CYCLES
  )
  (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // supply monitors
    input  wire logic                      core_supply_low,
    input  wire logic                      brownout_request,
    input  wire logic                      brownout_reset_allow,
    // watchdog
    input  wire logic                      wdt_fault,
    input  wire logic                      wdt_cpu_only,
    // software access
    input  wire logic                      ctrl_write,
    input  wire logic [31:0]               ctrl_data,
    input  wire logic                      status_read,
    input  wire reset_ctrl_pkg::mode_type  mode,
    output var  reset_ctrl_pkg::status_type status,
    output logic                           irq,
    // reset outputs
    output logic                           cpu_nreset,
    output logic                           periph_nreset,
    output logic                           cpu_clk_en,
    // system reset pin
    input  wire logic                      nrst_in,
    output logic                           nrst_out,
    output logic                           nrst_oe_n
  );
  import reset_ctrl_pkg::*;

  logic                   pin_meta_r;
  logic                   pin_sync_r;
  logic                   pin_prev_r;
  logic                   bod_meta_r;
  logic                   bod_sync_r;
  logic                   bod_prev_r;
  logic                   por_meta_r;
  logic                   por_sync_r;
  logic                   user_seen_r;
  logic                   bod_seen_r;
  logic [2:0]             cause_r;
  logic                   busy_r;
  logic                   irq_r;
  logic [PULSE_CNT_W-1:0] pulse_cnt_r;
  logic [PULSE_CNT_W-1:0] pulse_cnt_nxt;
  logic                   own_pulse_r;
  state_type              state_r;
  state_type              state_nxt;
  logic [PHASE_CNT_W-1:0] cnt_r;
  logic [PHASE_CNT_W-1:0] cnt_nxt;
  logic                   sw_cpu_r;
  logic                   sw_cpu_nxt;
  logic                   sw_periph_r;
  logic                   sw_periph_nxt;
  logic                   wd_cpu_only_r;
  logic                   wd_cpu_only_nxt;
  logic                   cpu_nreset_r;
  logic                   periph_nreset_r;
  logic                   cpu_clk_en_r;
  logic                   nrst_oe_n_r;
  logic                   accept;
  logic                   user_req;
  logic                   pulse_start;
  logic                   cause_load;
  logic [2:0]             cause_val;
  logic                   busy_clr;

  function automatic logic cnt_done(input logic [PHASE_CNT_W-1:0] c, input int len);
    cnt_done = (c == PHASE_CNT_W'(len - 1));
  endfunction

  // input synchronisers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      pin_prev_r <= 1'b1;
      bod_meta_r <= 1'b0;
      bod_sync_r <= 1'b0;
      bod_prev_r <= 1'b0;
      por_meta_r <= 1'b1;
      por_sync_r <= 1'b1;
    end
    else
    begin
      pin_meta_r <= nrst_in;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      bod_meta_r <= brownout_request;
      bod_sync_r <= bod_meta_r;
      bod_prev_r <= bod_sync_r;
      por_meta_r <= core_supply_low;
      por_sync_r <= por_meta_r;
    end
  end

  always_comb
  begin
    accept = ctrl_write && !busy_r && (state_r == ST_RUN)
          && (ctrl_data[CTRL_KEY_LSB +: 8] == CTRL_KEY_VALUE)
          && (ctrl_data[CTRL_CPU_BIT] || ctrl_data[CTRL_PERIPH_BIT]
              || ctrl_data[CTRL_PIN_BIT]);
    user_req = mode.user_reset_enable && !pin_sync_r && !own_pulse_r;
  end

  // reset state manager
  always_comb
  begin
    state_nxt       = state_r;
    cnt_nxt         = cnt_r;
    pulse_start     = 1'b0;
    cause_load      = 1'b0;
    cause_val       = cause_r;
    busy_clr        = 1'b0;
    sw_cpu_nxt      = accept ? ctrl_data[CTRL_CPU_BIT] : sw_cpu_r;
    sw_periph_nxt   = accept ? ctrl_data[CTRL_PERIPH_BIT] : sw_periph_r;
    wd_cpu_only_nxt = wd_cpu_only_r;
    if (por_sync_r)
    begin
      state_nxt = ST_STARTUP;
      cnt_nxt   = '0;
      busy_clr  = 1'b1;
    end
    else if (state_r == ST_STARTUP)
    begin
      cnt_nxt = cnt_r + 1'b1;
      if (cnt_done(cnt_r, STARTUP_LEN))
      begin
        state_nxt  = ST_RUN;
        cause_load = 1'b1;
        cause_val  = CAUSE_POWERUP;
      end
    end
    else if (bod_sync_r && brownout_reset_allow && state_r != ST_BROWN)
    begin
      state_nxt   = ST_BROWN;
      cnt_nxt     = '0;
      pulse_start = 1'b1;
      busy_clr    = 1'b1;
    end
    else if (wdt_fault && (state_r == ST_RUN || state_r == ST_SOFT))
    begin
      state_nxt       = ST_WDOG;
      cnt_nxt         = '0;
      wd_cpu_only_nxt = wdt_cpu_only;
      pulse_start     = !wdt_cpu_only;
      busy_clr        = 1'b1;
    end
    else
    begin
      case (state_r)
        ST_RUN:
        begin
          if (accept)
          begin
            state_nxt   = ST_SOFT;
            cnt_nxt     = '0;
            pulse_start = ctrl_data[CTRL_PIN_BIT];
          end
          else if (user_req)
          begin
            state_nxt = ST_USER;
            cnt_nxt   = '0;
          end
        end
        ST_USER:
        begin
          cnt_nxt = pin_sync_r ? cnt_r + 1'b1 : '0;
          if (pin_sync_r && cnt_done(cnt_r, CPU_STARTUP_CYCLES))
          begin
            state_nxt  = ST_RUN;
            cause_load = 1'b1;
            cause_val  = CAUSE_USER;
          end
        end
        ST_SOFT:
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_done(cnt_r, SW_RESET_CYCLES))
          begin
            state_nxt  = ST_RUN;
            busy_clr   = 1'b1;
            cause_load = sw_cpu_r;
            cause_val  = CAUSE_SOFTWARE;
          end
        end
        ST_WDOG:
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_done(cnt_r, WDOG_RESET_CYCLES))
          begin
            state_nxt  = ST_RUN;
            cause_load = 1'b1;
            cause_val  = CAUSE_WATCHDOG;
          end
        end
        ST_BROWN:
        begin
          cnt_nxt = bod_sync_r ? '0 : cnt_r + 1'b1;
          if (!bod_sync_r && cnt_done(cnt_r, BROWNOUT_EXIT_CYCLES))
          begin
            state_nxt  = ST_RUN;
            cause_load = 1'b1;
            cause_val  = CAUSE_BROWNOUT;
          end
        end
        default:
        begin
          state_nxt = ST_STARTUP;
          cnt_nxt   = '0;
        end
      endcase
    end
  end

  always_comb
  begin
    if (pulse_start)
      pulse_cnt_nxt = PULSE_CNT_W'(1) << (5'(mode.ext_reset_length_field) + 5'h01);
    else if (pulse_cnt_r != '0)
      pulse_cnt_nxt = pulse_cnt_r - 1'b1;
    else
      pulse_cnt_nxt = '0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r       <= ST_STARTUP;
      cnt_r         <= '0;
      sw_cpu_r      <= 1'b0;
      sw_periph_r   <= 1'b0;
      wd_cpu_only_r <= 1'b0;
      pulse_cnt_r   <= '0;
    end
    else
    begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      sw_cpu_r      <= sw_cpu_nxt;
      sw_periph_r   <= sw_periph_nxt;
      wd_cpu_only_r <= wd_cpu_only_nxt;
      pulse_cnt_r   <= pulse_cnt_nxt;
    end
  end

  // marks pin lows caused by our own drive until the pin is seen high again
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      own_pulse_r <= 1'b1;
    else if (pulse_start || state_nxt == ST_STARTUP)
      own_pulse_r <= 1'b1;
    else if (pulse_cnt_r == '0 && pin_sync_r)
      own_pulse_r <= 1'b0;
  end

  // reset outputs, registered from the next state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cpu_nreset_r    <= 1'b0;
      periph_nreset_r <= 1'b0;
      cpu_clk_en_r    <= 1'b0;
      nrst_oe_n_r     <= 1'b0;
    end
    else
    begin
      cpu_nreset_r    <= !(state_nxt == ST_STARTUP || state_nxt == ST_USER
                        || state_nxt == ST_BROWN || state_nxt == ST_WDOG
                        || (state_nxt == ST_SOFT && sw_cpu_nxt));
      periph_nreset_r <= !(state_nxt == ST_STARTUP || state_nxt == ST_USER
                        || state_nxt == ST_BROWN
                        || (state_nxt == ST_WDOG && !wd_cpu_only_nxt)
                        || (state_nxt == ST_SOFT && sw_periph_nxt));
      cpu_clk_en_r    <= !(state_nxt == ST_STARTUP
                        || (state_nxt == ST_USER && !pin_sync_r));
      nrst_oe_n_r     <= !(state_nxt == ST_STARTUP || pulse_cnt_nxt != '0);
    end
  end

  // status flags; a new event wins over a read clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      user_seen_r <= 1'b0;
      bod_seen_r  <= 1'b0;
      cause_r     <= CAUSE_RST;
      busy_r      <= 1'b0;
      irq_r       <= 1'b0;
    end
    else
    begin
      user_seen_r <= (pin_prev_r && !pin_sync_r) || (user_seen_r && !status_read);
      bod_seen_r  <= (!brownout_reset_allow && bod_sync_r && !bod_prev_r)
                  || (bod_seen_r && !status_read);
      if (cause_load)
        cause_r <= cause_val;
      if (accept)
        busy_r <= 1'b1;
      else if (busy_clr)
        busy_r <= 1'b0;
      irq_r <= (user_seen_r && !status_read && mode.user_reset_irq_enable
                && !mode.user_reset_enable)
            || (bod_seen_r && !status_read && mode.brownout_irq_enable);
    end
  end

  assign status = '{sw_reset_busy:        busy_r,
                    pin_level_flag:       pin_sync_r,
                    last_reset_cause:     cause_r,
                    brownout_seen_flag:   bod_seen_r,
                    user_reset_seen_flag: user_seen_r};
  assign irq           = irq_r;
  assign cpu_nreset    = cpu_nreset_r;
  assign periph_nreset = periph_nreset_r;
  assign cpu_clk_en    = cpu_clk_en_r;
  assign nrst_out      = 1'b0;
  assign nrst_oe_n     = nrst_oe_n_r;

endmodule

`default_nettype wire

// *** tb/board_reset_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module board_reset_device
  (
    // clock
    input wire logic       clk,
    // board side request
    input wire logic       hold_req,
    input wire logic [3:0] stretch,
    // shared open-drain line
    input wire logic       nrst_out,
    input wire logic       nrst_oe_n,
    output logic           pin
  );
  logic [4:0] hold_cnt_r = 5'h00;
  // board holds the line while asked, then lets go after a slow tail
  always_ff @(posedge clk)
  begin
    if (hold_req)
      hold_cnt_r <= {1'b0, stretch} + 5'h01;
    else if (hold_cnt_r != 5'h00)
      hold_cnt_r <= hold_cnt_r - 5'h01;
  end
  // pull-up: a released line reads high
  assign pin = (hold_cnt_r == 5'h00) && (nrst_oe_n || nrst_out);
endmodule
`default_nettype wire

// *** tb/system_reset_controller_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_checker
  #(
    parameter int STARTUP_LEN = 4
  )
  (
    // clock and sources
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic core_supply_low,
    input wire logic brownout_request,
    input wire logic brownout_reset_allow,
    input wire logic wdt_fault,
    input wire logic wdt_cpu_only,
    // software access
    input wire logic ctrl_write,
    input wire logic [31:0] ctrl_data,
    input wire logic status_read,
    input wire reset_ctrl_pkg::mode_type mode,
    input wire reset_ctrl_pkg::status_type status,
    input wire logic irq,
    // resets and pin
    input wire logic cpu_nreset,
    input wire logic periph_nreset,
    input wire logic cpu_clk_en,
    input wire logic nrst_in,
    input wire logic nrst_out,
    input wire logic nrst_oe_n
  );
  import reset_ctrl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic run, acc, irq_nxt, armed_r;
  logic [16:0] low_cnt_r, len_r;
  assign run = cpu_nreset && periph_nreset && nrst_oe_n && !status.sw_reset_busy;
  assign acc = ctrl_write && run && !wdt_fault && ctrl_data[CTRL_KEY_LSB +: 8] == CTRL_KEY_VALUE
    && (ctrl_data[CTRL_CPU_BIT] || ctrl_data[CTRL_PERIPH_BIT] || ctrl_data[CTRL_PIN_BIT]);
  assign irq_nxt = (status.user_reset_seen_flag && mode.user_reset_irq_enable
    && !mode.user_reset_enable) || (status.brownout_seen_flag && mode.brownout_irq_enable);
  // length of the current low drive on the pin
  always_ff @(posedge clk)
  begin
    low_cnt_r <= (sys_rst || nrst_oe_n) ? 17'h0_0000 : low_cnt_r + 17'h0_0001;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || (nrst_oe_n && low_cnt_r != 17'h0_0000))
      armed_r <= 1'b0;
    else if (acc && ctrl_data[CTRL_PIN_BIT])
      armed_r <= 1'b1;
    if (acc)
      len_r <= 17'h0_0002 << mode.ext_reset_length_field;
  end
  sequence s_busy_span;
    status.sw_reset_busy [*3] ##1 !status.sw_reset_busy;
  endsequence
  sequence s_cpu_pulse;
    !cpu_nreset [*3] ##1 cpu_nreset;
  endsequence
  a_busy_span: assert property (acc |=> s_busy_span)
    else $error("busy span wrong");
  a_cpu_pulse: assert property (acc && ctrl_data[CTRL_CPU_BIT] |=> s_cpu_pulse)
    else $error("cpu reset span wrong");
  a_sw_cause: assert property (acc && ctrl_data[CTRL_CPU_BIT]
    |=> ##3 status.last_reset_cause == CAUSE_SOFTWARE)
    else $error("software cause missing");
  a_cause_kept: assert property (acc && !ctrl_data[CTRL_CPU_BIT]
    |=> $stable(status.last_reset_cause) [*4])
    else $error("cause changed");
  a_key_refuse: assert property (ctrl_write && run
    && ctrl_data[CTRL_KEY_LSB +: 8] != CTRL_KEY_VALUE |=> !status.sw_reset_busy)
    else $error("bad key taken");
  a_pin_len: assert property ($rose(nrst_oe_n) && armed_r |-> low_cnt_r == len_r)
    else $error("pin pulse length wrong");
  a_irq_or: assert property (1'b1 |=> irq == ($past(irq_nxt) && !$past(status_read)))
    else $error("interrupt wrong");
  a_user_enter: assert property ($fell(nrst_in) && mode.user_reset_enable && run
    |-> ##[1:4] !cpu_nreset && !periph_nreset)
    else $error("user reset missing");
  a_user_off: assert property ($fell(nrst_in) && !mode.user_reset_enable && run
    |=> cpu_nreset [*6])
    else $error("disabled user reset taken");
  a_user_exit: assert property ($rose(cpu_clk_en) && !cpu_nreset |-> ##[1:4] cpu_nreset)
    else $error("user reset exit late");
  a_bod_flag: assert property ($rose(brownout_request) && !brownout_reset_allow
    |-> ##[1:4] status.brownout_seen_flag)
    else $error("brownout flag missing");
  a_bod_reset: assert property ($rose(brownout_request) && brownout_reset_allow && run
    |-> ##[1:4] !cpu_nreset && !periph_nreset)
    else $error("brownout reset missing");
  a_supply_low: assert property ($rose(core_supply_low)
    |-> ##[1:4] !cpu_nreset && !periph_nreset)
    else $error("supply low reset missing");
endmodule
bind system_reset_controller system_reset_controller_checker #(.STARTUP_LEN(STARTUP_LEN)) chk (.*);
`default_nettype wire

// *** tb/system_reset_controller_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_tb_top;
  import reset_ctrl_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, core_supply_low = 1'b0, brownout_request = 1'b0;
  logic brownout_reset_allow = 1'b0, wdt_fault = 1'b0, wdt_cpu_only = 1'b0;
  logic ctrl_write = 1'b0, status_read = 1'b0, hold_req = 1'b0, prev_r = 1'b0;
  logic [31:0] ctrl_data = 32'h0000_0000;
  logic [3:0] stretch = 4'h0;
  logic [3:0] cmds [4] = '{4'h1, 4'h5, 4'h8, 4'hD};
  logic [15:0] rnd = 16'h0010;
  mode_type mode = '0;
  status_type status;
  logic irq, cpu_nreset, periph_nreset, cpu_clk_en, nrst_out, nrst_oe_n;
  wire logic nrst_in;
  int mismatches = 0, comparisons = 0;
  logic [2:0] cause_q [$];
  system_reset_controller #(.STARTUP_LEN(4)) DUT (.*);
  board_reset_device board (.clk(clk), .hold_req(hold_req), .stretch(stretch),
    .nrst_out(nrst_out), .nrst_oe_n(nrst_oe_n), .pin(nrst_in));
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_run;
    int n = 0;
    while ({cpu_nreset, periph_nreset, nrst_oe_n, status.sw_reset_busy, nrst_in} !== 5'b11101)
    begin
      @(posedge clk);
      n++;
      if (n > 400)
      begin
        mismatches++;
        test_done();
      end
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic write_ctrl(input logic [7:0] key, input logic [3:0] cmd);
    @(posedge clk);
    ctrl_write <= 1'b1;
    ctrl_data <= {key, 20'h0_0000, cmd};
    @(posedge clk);
    ctrl_write <= 1'b0;
  endtask
  task automatic read_status;
    @(posedge clk);
    status_read <= 1'b1;
    @(posedge clk);
    status_read <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // each processor release takes the oldest expected cause
  always @(posedge clk)
  begin
    if (!sys_rst && cpu_nreset === 1'b1 && prev_r === 1'b0)
    begin
      if (cause_q.size() == 0)
        check("unexpected release", 32'h1, 32'h0);
      else
        check("cause", status.last_reset_cause, cause_q.pop_front());
    end
    prev_r <= cpu_nreset;
  end
  initial
  begin
    cause_q.push_back(CAUSE_POWERUP);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    wait_run();
    check("pin level", status.pin_level_flag, 1);
    foreach (cmds[i])
    begin
      rnd = lfsr(rnd);
      mode <= '{1'b0, {2'b00, rnd[1:0]}, 1'b0, 1'b1};
      stretch <= rnd[7:4];
      write_ctrl(8'hA5 ^ {rnd[15:9], 1'b1}, cmds[i]);
      repeat (2) @(posedge clk);
      check("busy bad key", status.sw_reset_busy, 0);
      write_ctrl(CTRL_KEY_VALUE, cmds[i]);
      if (cmds[i][CTRL_CPU_BIT])
        cause_q.push_back(CAUSE_SOFTWARE);
      @(posedge clk);
      check("busy", status.sw_reset_busy, 1);
      check("periph", periph_nreset, !cmds[i][CTRL_PERIPH_BIT]);
      write_ctrl(CTRL_KEY_VALUE, 4'h1);
      wait_run();
    end
    mode <= '{1'b1, 4'h0, 1'b1, 1'b0};
    read_status();
    check("user flag before hold", status.user_reset_seen_flag, 0);
    check("irq before hold", irq, 0);
    hold_req <= 1'b1;
    repeat (6) @(posedge clk);
    hold_req <= 1'b0;
    repeat (24) @(posedge clk);
    check("user flag", status.user_reset_seen_flag, 1);
    check("irq user", irq, 1);
    check("no user reset", cpu_nreset, 1);
    read_status();
    check("user flag cleared", status.user_reset_seen_flag, 0);
    check("irq cleared", irq, 0);
    brownout_request <= 1'b1;
    repeat (6) @(posedge clk);
    check("brownout flag", status.brownout_seen_flag, 1);
    check("irq brownout", irq, 1);
    check("no brownout reset", cpu_nreset, 1);
    brownout_request <= 1'b0;
    read_status();
    check("brownout flag cleared", status.brownout_seen_flag, 0);
    check("irq brownout cleared", irq, 0);
    mode <= '{1'b0, 4'h1, 1'b0, 1'b1};
    cause_q.push_back(CAUSE_USER);
    hold_req <= 1'b1;
    repeat (30) @(posedge clk);
    check("held by pin", cpu_nreset, 0);
    check("clock off", cpu_clk_en, 0);
    hold_req <= 1'b0;
    wait_run();
    brownout_reset_allow <= 1'b1;
    cause_q.push_back(CAUSE_BROWNOUT);
    brownout_request <= 1'b1;
    repeat (6) @(posedge clk);
    check("brownout periph", periph_nreset, 0);
    brownout_request <= 1'b0;
    wait_run();
    brownout_reset_allow <= 1'b0;
    cause_q.push_back(CAUSE_WATCHDOG);
    wdt_cpu_only <= rnd[0];
    wdt_fault <= 1'b1;
    @(posedge clk);
    wdt_fault <= 1'b0;
    wait_run();
    cause_q.push_back(CAUSE_POWERUP);
    core_supply_low <= 1'b1;
    repeat (6) @(posedge clk);
    check("supply low", cpu_nreset, 0);
    core_supply_low <= 1'b0;
    wait_run();
    read_status();
    check("cause kept", status.last_reset_cause, CAUSE_POWERUP);
    check("queue empty", cause_q.size(), 0);
    test_done();
  end
endmodule
`default_nettype wire
